// ==== core/cfs_serial_regs.sv ====
// serial control bank of the ccd front end: shifter on the link clock,
// four write-only registers and decoded controls on the core clock
// assumes the host drives link_clk_i, serial_word_bit_i and serial_enable_i
// assumes the link and the pulse pins run apart from clock_i
`timescale 1ns/100ps

module cfs_serial_regs
	import cfs_pkg::*;
#(
	parameter int WORD_W = WORD_BITS
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             link_clk_i,
	input  wire logic             serial_enable_i,
	input  wire logic             serial_word_bit_i,
	input  wire logic             signal_sample_pulse_i,
	input  wire logic             black_sample_pulse_i,
	input  wire logic             optical_black_pulse_i,
	output cfs_ctrl_s             ctrl_o,
	output cfs_pulse_s            pulse_o,
	output logic                  processing_enable_o,
	output logic                  reference_enable_o,
	output logic [WORD_W-1:0]     clamp_reg_o,
	output logic [WORD_W-1:0]     test_reg_o,
	output logic                  word_strobe_o
);

	// ==========================================================
	// link domain: shift one word while the frame is open
	// the frame signal clears the count, so no link edge is needed
	// between frames; bits beyond the word length are ignored
	localparam int CNT_W = $clog2(WORD_W + 1);

	logic [WORD_W-1:0] shift_q;
	logic [CNT_W-1:0]  bit_cnt_q;
	logic              word_ready_q;
	logic              word_full;
	logic              last_bit;

	// the count stops at the word length, which makes a long frame
	// harmless: the extra edges find the shifter closed
	assign word_full = (bit_cnt_q == CNT_W'(WORD_W));
	assign last_bit  = (bit_cnt_q == CNT_W'(WORD_W - 1));

	always_ff @(posedge link_clk_i or negedge serial_enable_i) begin
		if (!serial_enable_i) begin
			bit_cnt_q <= '0;
		end else if (!word_full) begin
			bit_cnt_q <= bit_cnt_q + CNT_W'(1);
		end
	end

	// least significant bit arrives first
	always_ff @(posedge link_clk_i) begin
		if (serial_enable_i && !word_full) begin
			shift_q <= {serial_word_bit_i, shift_q[WORD_W-1:1]};
		end
	end

	// level held from the last bit until the frame closes; a frame that
	// closes early never raises it, so a cut word writes nothing
	always_ff @(posedge link_clk_i or negedge serial_enable_i) begin
		if (!serial_enable_i) begin
			word_ready_q <= 1'b0;
		end else if (last_bit) begin
			word_ready_q <= 1'b1;
		end
	end

	// ==========================================================
	// crossing: the ready level is synchronised; the word itself is
	// stable from ready until the next frame shifts, so it is read
	// directly once the synchronised level has risen
	logic [SYNC_STAGES-1:0] ready_sync_q;
	logic                   ready_synced;
	logic                   ready_seen_q;
	logic                   take_word;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ready_sync_q <= '0;
		end else begin
			ready_sync_q <= {ready_sync_q[SYNC_STAGES-2:0], word_ready_q};
		end
	end

	// only the last stage is read, never the first
	assign ready_synced = ready_sync_q[SYNC_STAGES-1];

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ready_seen_q <= 1'b0;
		end else begin
			ready_seen_q <= ready_synced;
		end
	end

	// one take per frame: the level rises once and stays until the frame
	// closes, so its rising edge is seen exactly once
	assign take_word = ready_synced && !ready_seen_q;

	// ==========================================================
	// register bank
	localparam int N_REGS = 1 << SEL_BITS;

	logic [WORD_W-1:0]   gain_reg_q;
	logic [WORD_W-1:0]   mode_reg_q;
	logic [WORD_W-1:0]   clamp_reg_q;
	logic [WORD_W-1:0]   test_reg_q;
	logic [SEL_BITS-1:0] word_sel;
	logic                take_q;

	// true when the select field of a word names register idx
	function automatic logic sel_hits(input logic [SEL_BITS-1:0] sel, input int idx);
		logic hit;
		hit = 1'b0;
		if (idx == 0) begin
			hit = (sel == SEL_GAIN);
		end else if (idx == 1) begin
			hit = (sel == SEL_MODE);
		end else if (idx == 2) begin
			hit = (sel == SEL_CLMP);
		end else begin
			hit = (sel == SEL_TEST);
		end
		return hit;
	endfunction

	// value each register takes while rst_i is high
	function automatic logic [WORD_W-1:0] reg_reset(input int idx);
		logic [WORD_W-1:0] value;
		value = WORD_W'(TEST_RST);
		if (idx == 0) begin
			value = WORD_W'(GAIN_RST);
		end else if (idx == 1) begin
			value = WORD_W'(MODE_RST);
		end else if (idx == 2) begin
			value = WORD_W'(CLMP_RST);
		end
		return value;
	endfunction

	assign word_sel = shift_q[SEL_LSB +: SEL_BITS];

	// a word is kept whole, fixed and test bits included: the device
	// does not police the pattern that the host writes
	for (genvar g = 0; g < N_REGS; g++) begin : g_bank
		logic [WORD_W-1:0] word_q;

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				word_q <= reg_reset(g);
			end else if (take_word && sel_hits(word_sel, g)) begin
				word_q <= shift_q;
			end
		end
	end

	assign gain_reg_q  = g_bank[0].word_q;
	assign mode_reg_q  = g_bank[1].word_q;
	assign clamp_reg_q = g_bank[2].word_q;
	assign test_reg_q  = g_bank[3].word_q;

	// the strobe trails the write by one edge, so it marks the cycle in
	// which the registered controls first show the new word
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			take_q <= 1'b0;
		end else begin
			take_q <= take_word;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			word_strobe_o <= 1'b0;
		end else begin
			word_strobe_o <= take_q;
		end
	end

	// ==========================================================
	// decoded controls, registered so every output comes from a flop
	cfs_ctrl_s ctrl_d;

	always_comb begin
		ctrl_d.gain_code            = gain_reg_q[GAIN_LSB +: GAIN_BITS];
		ctrl_d.standby              = gain_reg_q[STANDBY_BIT];
		ctrl_d.sample_pulse_invert  = mode_reg_q[PULSE_INV_BIT];
		ctrl_d.black_pulse_polarity = mode_reg_q[OB_POL_BIT];
		ctrl_d.clock_range_select   = mode_reg_q[CLK_RANGE_BIT];
		ctrl_d.offset_cancel_enable = mode_reg_q[OFS_EN_BIT];
		ctrl_d.offset_voltage_code  = mode_reg_q[OFS_CODE_LSB +: OFS_CODE_BITS];
		ctrl_d.output_invert_a      = mode_reg_q[INV_A_BIT];
		ctrl_d.output_invert_b      = mode_reg_q[INV_B_BIT];
		ctrl_d.test_output_mode     = mode_reg_q[TEST_OUT_BIT];
		ctrl_d.mode_reset           = !mode_reg_q[RUN_BIT];
		ctrl_d.offset_cal_mode      = mode_reg_q[OFS_CAL_BIT];
		ctrl_d.sleep_select         = mode_reg_q[SLEEP_BIT];
		ctrl_d.clamp_level          = clamp_reg_q[CLAMP_LSB +: CLAMP_BITS];
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctrl_o <= '0;
		end else begin
			ctrl_o <= ctrl_d;
		end
	end

	// standby stops processing but keeps the reference alive; reset mode
	// and sleep stop processing as well
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			processing_enable_o <= 1'b0;
		end else begin
			processing_enable_o <= !ctrl_d.standby && !ctrl_d.sleep_select && !ctrl_d.mode_reset;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reference_enable_o <= 1'b0;
		end else begin
			reference_enable_o <= !ctrl_d.sleep_select;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			clamp_reg_o <= WORD_W'(CLMP_RST);
		end else begin
			clamp_reg_o <= clamp_reg_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			test_reg_o <= WORD_W'(TEST_RST);
		end else begin
			test_reg_o <= test_reg_q;
		end
	end

	// ==========================================================
	// sampling pulse pins: two flops each, then polarity handling
	localparam int N_PINS = 3;

	logic [N_PINS-1:0] pin_raw;
	logic [N_PINS-1:0] pin_sync;

	assign pin_raw = {signal_sample_pulse_i, black_sample_pulse_i, optical_black_pulse_i};

	// only the last stage of each chain is read, so a metastable first
	// stage never reaches the polarity logic
	for (genvar p = 0; p < N_PINS; p++) begin : g_pin_sync
		logic [SYNC_STAGES-1:0] stage_q;

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				stage_q <= '0;
			end else begin
				stage_q <= {stage_q[SYNC_STAGES-2:0], pin_raw[p]};
			end
		end

		assign pin_sync[p] = stage_q[SYNC_STAGES-1];
	end

	// a pin reads active high once xored with its invert flag
	function automatic logic active_level(input logic pin, input logic invert);
		return pin ^ invert;
	endfunction

	// the inversion applies to both sampling pulses alike
	cfs_pulse_s pulse_d;

	always_comb begin
		pulse_d.signal_sample        = active_level(pin_sync[2], ctrl_d.sample_pulse_invert);
		pulse_d.black_sample         = active_level(pin_sync[1], ctrl_d.sample_pulse_invert);
		// polarity low means the pin is active low
		pulse_d.optical_black_active = active_level(pin_sync[0], !ctrl_d.black_pulse_polarity);
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pulse_o <= '0;
		end else begin
			pulse_o <= pulse_d;
		end
	end

endmodule

// ==== core/cfs_pkg.sv ====
// package of the serial control bank of the ccd front end
// assumes nothing beyond a systemverilog compiler
package cfs_pkg;

	// ==========================================================
	// serial word layout
	localparam int WORD_BITS        = 16;
	localparam int SEL_LSB          = 0;
	localparam int SEL_BITS         = 2;
	localparam logic [1:0] SEL_GAIN = 2'h0;
	localparam logic [1:0] SEL_MODE = 2'h1;
	localparam logic [1:0] SEL_CLMP = 2'h2;
	localparam logic [1:0] SEL_TEST = 2'h3;

	// ==========================================================
	// gain_and_standby_control fields
	localparam int GAIN_LSB    = 2;
	localparam int GAIN_BITS   = 11;
	localparam int R0_TEST_LSB = 13;
	localparam int STANDBY_BIT = 15;

	// ==========================================================
	// pulse_offset_mode_control fields
	localparam int PULSE_INV_BIT  = 2;
	localparam int OB_POL_BIT     = 3;
	localparam int CLK_RANGE_BIT  = 4;
	localparam int OFS_EN_BIT     = 5;
	localparam int OFS_CODE_LSB   = 6;
	localparam int OFS_CODE_BITS  = 4;
	localparam int INV_A_BIT      = 10;
	localparam int INV_B_BIT      = 11;
	localparam int TEST_OUT_BIT   = 12;
	localparam int RUN_BIT        = 13;
	localparam int OFS_CAL_BIT    = 14;
	localparam int SLEEP_BIT      = 15;

	// ==========================================================
	// clamp_level_control fields
	localparam int CLAMP_LSB  = 2;
	localparam int CLAMP_BITS = 5;

	// ==========================================================
	// reset values of the four registers
	localparam logic [15:0] GAIN_RST = 16'h0000;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] CLMP_RST = 16'h0000;
	localparam logic [15:0] TEST_RST = 16'h0000;

	// synchroniser depth for pins and for the word-ready level
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// decoded controls handed to the analog and converter logic
	typedef struct packed {
		logic [10:0] gain_code;
		logic        standby;
		logic        sample_pulse_invert;
		logic        black_pulse_polarity;
		logic        clock_range_select;
		logic        offset_cancel_enable;
		logic [3:0]  offset_voltage_code;
		logic        output_invert_a;
		logic        output_invert_b;
		logic        test_output_mode;
		logic        mode_reset;
		logic        offset_cal_mode;
		logic        sleep_select;
		logic [4:0]  clamp_level;
	} cfs_ctrl_s;

	// sampled pulses after polarity handling
	typedef struct packed {
		logic signal_sample;
		logic black_sample;
		logic optical_black_active;
	} cfs_pulse_s;

endpackage

// ==== tb/cfs_serial_chk.sv ====
// port checker of the serial control bank
// assumes it is bound to every instance of the bank
`timescale 1ns/100ps
module cfs_serial_chk
	import cfs_pkg::*;
#(
	parameter int WORD_W = 16
) (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        serial_enable_i,
	input wire logic        signal_sample_pulse_i,
	input wire logic        black_sample_pulse_i,
	input wire logic        optical_black_pulse_i,
	input cfs_ctrl_s        ctrl_o,
	input cfs_pulse_s       pulse_o,
	input wire logic        processing_enable_o,
	input wire logic        reference_enable_o,
	input wire logic [WORD_W-1:0] clamp_reg_o,
	input wire logic        word_strobe_o
);
	// ========
	// properties
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	strobe_spacing_a: assert property (
		word_strobe_o |=> !word_strobe_o [*8]) else $error("strobe too long or too close");
	strobe_in_frame_a: assert property (
		word_strobe_o |-> serial_enable_i) else $error("strobe outside a frame");
	ctrl_on_write_a: assert property (
		$changed(ctrl_o) && !$past(rst_i, 2) |-> word_strobe_o) else $error("controls moved without a write");
	proc_enable_a: assert property (
		word_strobe_o |-> processing_enable_o == !(ctrl_o.standby || ctrl_o.sleep_select || ctrl_o.mode_reset))
		else $error("processing enable wrong");
	ref_enable_a: assert property (
		word_strobe_o |-> reference_enable_o == !ctrl_o.sleep_select) else $error("reference enable wrong");
	clamp_copy_a: assert property (
		word_strobe_o |-> ctrl_o.clamp_level == clamp_reg_o[6:2]) else $error("clamp level wrong");
	// the 3-cycle window keeps a polarity change out of the comparison
	sig_pulse_a: assert property (
		$past(ctrl_o, 3) == ctrl_o && !$past(rst_i, 4) |->
		pulse_o.signal_sample == ($past(signal_sample_pulse_i, 3) ^ ctrl_o.sample_pulse_invert))
		else $error("signal pulse wrong");
	blk_pulse_a: assert property (
		$past(ctrl_o, 3) == ctrl_o && !$past(rst_i, 4) |->
		pulse_o.black_sample == ($past(black_sample_pulse_i, 3) ^ ctrl_o.sample_pulse_invert))
		else $error("black pulse wrong");
	ob_pulse_a: assert property (
		$past(ctrl_o, 3) == ctrl_o && !$past(rst_i, 4) |->
		pulse_o.optical_black_active == ($past(optical_black_pulse_i, 3) ^ !ctrl_o.black_pulse_polarity))
		else $error("optical black pulse wrong");
endmodule
bind cfs_serial_regs cfs_serial_chk #(.WORD_W(WORD_W)) u_cfs_serial_chk (.clock_i(clock_i), .rst_i(rst_i),
	.serial_enable_i(serial_enable_i), .signal_sample_pulse_i(signal_sample_pulse_i),
	.black_sample_pulse_i(black_sample_pulse_i), .optical_black_pulse_i(optical_black_pulse_i),
	.ctrl_o(ctrl_o), .pulse_o(pulse_o), .processing_enable_o(processing_enable_o),
	.reference_enable_o(reference_enable_o), .clamp_reg_o(clamp_reg_o), .word_strobe_o(word_strobe_o));

// ==== tb/cfs_host_model.sv ====
// host side of the serial link, shifting words lsb first on its own clock
// assumes callers wait for send to return before the next frame
`timescale 1ns/100ps
module cfs_host_model (
	output logic link_clk_o,
	output logic enable_o,
	output logic data_o
);
	initial begin
		link_clk_o = 1'b0;
		enable_o   = 1'b0;
		data_o     = 1'b0;
	end
	// link clock stands low between frames; released data shows the inverse
	task automatic send(input logic [15:0] w, input int n);
		#7.3;
		enable_o = 1'b1;
		for (int i = 0; i < n; i++) begin
			data_o = w[i];
			#62.5 link_clk_o = 1'b1;
			#62.5 link_clk_o = 1'b0;
		end
		data_o = ~data_o;
		#250 enable_o = 1'b0;
		#125;
	endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the serial control bank
// assumes the host model alone drives the link pins
`timescale 1ns/100ps
module testbench;
	import cfs_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [2:0]  pins = 3'h0;
	logic        link_clk, link_en, link_bit, proc_en, ref_en, strobe;
	cfs_ctrl_s   ctrl;
	cfs_pulse_s  pulse;
	logic [15:0] clamp_reg, test_reg;
	logic [15:0] r [4] = '{default: 16'h0000};
	int          fail_count = 0;
	int          n_compared = 0;
	int          n_strobe = 0;
	int          n_wr = 0;
	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) if (strobe === 1'b1) n_strobe++;
	cfs_host_model u_cfs_host_model (.link_clk_o(link_clk), .enable_o(link_en), .data_o(link_bit));
	cfs_serial_regs u_cfs_serial_regs (.clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk),
		.serial_enable_i(link_en), .serial_word_bit_i(link_bit), .signal_sample_pulse_i(pins[2]),
		.black_sample_pulse_i(pins[1]), .optical_black_pulse_i(pins[0]), .ctrl_o(ctrl), .pulse_o(pulse),
		.processing_enable_o(proc_en), .reference_enable_o(ref_en), .clamp_reg_o(clamp_reg),
		.test_reg_o(test_reg), .word_strobe_o(strobe));
	// ========
	// helpers
	function automatic cfs_ctrl_s ex();
		return cfs_ctrl_s'({r[0][12:2], r[0][15], r[1][2], r[1][3], r[1][4], r[1][5], r[1][9:6],
			r[1][10], r[1][11], r[1][12], ~r[1][13], r[1][14], r[1][15], r[2][6:2]});
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check_all();
		@(posedge clock_i);
		#1;
		chk(ctrl, ex());
		chk(proc_en, !(r[0][15] | r[1][15] | !r[1][13]));
		chk(ref_en, !r[1][15]);
		chk(clamp_reg, r[2]);
		chk(test_reg, r[3]);
		chk(n_strobe, n_wr);
	endtask
	// a short frame must leave every register untouched
	task automatic wr(input logic [15:0] w, input int n);
		u_cfs_host_model.send(w, n);
		if (n == 16) begin
			r[w[1:0]] = w;
			n_wr++;
		end
		check_all();
	endtask
	// ========
	// tests
	initial begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		check_all();
		$display("test reset done");
		wr(16'h2001, 16);
		wr(16'h1554, 16);
		wr(16'h9ffc, 16);
		for (int i = 2; i < 16; i++) wr(16'h2001 | (16'h0001 << i), 16);
		wr(16'he87e, 16);
		wr(16'he842, 16);
		wr(16'h0003, 10);
		wr(16'h0003, 16);
		$display("test registers done");
		for (int k = 0; k < 2; k++) begin
			wr(k ? 16'h2001 : 16'h200d, 16);
			for (int p = 0; p < 8; p++) begin
				@(posedge clock_i);
				pins <= p[2:0];
				repeat (5) @(posedge clock_i);
				#1;
				chk(pulse, {p[2] ^ r[1][2], p[1] ^ r[1][2], p[0] ^ ~r[1][3]});
			end
		end
		$display("test pulses done");
		complete_run();
	end
	initial begin
		#200000;
		fail_count++;
		complete_run();
	end
endmodule
